// ### design/iqtl_pkg.sv
// Behaviour
// - Sampling-period field spans 0 to 0xFF; zero passes inputs through unfiltered.
// - With field n nonzero, each input is sampled once every 2n clocks.
// - A new level is accepted only after six equal consecutive samples.
// - Qualification time is five sampling windows plus one more window.
// - Trip low puts its PWM pair in high impedance within qualification time plus three clocks.
// - Protect input low forces all PWM outputs into high impedance.
// - Valid interrupt edge starts vector fetch within qualification time plus twelve clocks.
// - After protect returns high, PWM drive follows the output-enable bit, not auto release.
// - Conversion strobe falls within one clock, then stays low 32 peripheral clocks.
// - General-purpose outputs change within one clock of the clock edge.
package iqtl_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int IQTL_NUM_TRIP = 2;
    localparam int IQTL_NUM_INT  = 2;
    localparam int IQTL_NUM_PWM  = 2 * IQTL_NUM_TRIP;
    localparam int IQTL_NUM_GPO  = 4;
    localparam int IQTL_PRD_W    = 8;
    localparam int IQTL_CNT_W    = IQTL_PRD_W + 1;
    localparam int IQTL_HIST_LEN = 6;
    localparam int IQTL_IDX_W    = (IQTL_NUM_INT > 1) ? $clog2(IQTL_NUM_INT) : 1;
    localparam int IQTL_LAT_W    = 4;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic                  IQTL_IDLE_LVL   = 1'h1;
    localparam logic                  IQTL_OE_RST     = 1'h0;
    localparam logic [IQTL_CNT_W-1:0] IQTL_CNT_ONE    = 9'h001;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int IQTL_CLK_PERIOD_NS = 40;
    localparam int IQTL_HSP_PERIOD_NS = 40;
    localparam int IQTL_SOC_LOW_HSP   = 32;
    localparam int IQTL_SOC_LOW_NS    = IQTL_SOC_LOW_HSP * IQTL_HSP_PERIOD_NS;
    localparam int IQTL_SOC_LOW_CYC   =
        (IQTL_SOC_LOW_NS + IQTL_CLK_PERIOD_NS - 1) / IQTL_CLK_PERIOD_NS;
    localparam int IQTL_SOC_CNT_W     = $clog2(IQTL_SOC_LOW_CYC + 1);
    localparam int IQTL_TRIP_MAX_CYC  = 3;
    localparam int IQTL_INT_MAX_CYC   = 12;
    localparam int IQTL_INT_LAT_CYC   = 4;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic                     pdp_n;
        logic [IQTL_NUM_TRIP-1:0] trip_n;
        logic [IQTL_NUM_INT-1:0]  ext_int;
    } iqtl_pins_type;

    localparam int IQTL_PIN_W = $bits(iqtl_pins_type);

    typedef struct packed {
        logic                  valid;
        logic [IQTL_IDX_W-1:0] idx;
    } iqtl_fetch_type;

    // Sampling window length of 2n clocks
    function automatic logic [IQTL_CNT_W-1:0] iqtl_window(input logic [IQTL_PRD_W-1:0] n);
        return {n, 1'b0};
    endfunction : iqtl_window

endpackage : iqtl_pkg

// ### design/iqtl_qual.sv
`timescale 1ns/1ns
module iqtl_qual #(
    parameter int W = iqtl_pkg::IQTL_PIN_W
) (
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire logic                            ce_i,
    input  wire logic [iqtl_pkg::IQTL_PRD_W-1:0] period_i,
    input  wire logic [W-1:0]                    pin_i,
    output logic      [W-1:0]                    qual_o
);
    import iqtl_pkg::*;

    typedef struct packed {
        logic [IQTL_CNT_W-1:0]            cnt;
        logic [IQTL_HIST_LEN-1:0][W-1:0]  hist;
        logic [W-1:0]                     lvl;
    } iqtl_qst_type;

    iqtl_qst_type q;
    iqtl_qst_type d;

    function automatic logic iqtl_agree(input iqtl_qst_type s, input int b, input logic v);
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < IQTL_HIST_LEN; k++) begin
            ok = ok & (s.hist[k][b] == v);
        end
        return ok;
    endfunction : iqtl_agree

    always_comb begin
        d = q;
        if (period_i == '0) begin
            // Bypass keeps the history primed so re-enabling raises no false edge
            d.cnt  = '0;
            d.hist = {IQTL_HIST_LEN{pin_i}};
            d.lvl  = pin_i;
        end else begin
            if (q.cnt >= iqtl_window(period_i) - IQTL_CNT_ONE) begin
                d.cnt  = '0;
                d.hist = {q.hist[IQTL_HIST_LEN-2:0], pin_i};
            end else begin
                d.cnt = q.cnt + IQTL_CNT_ONE;
            end
            for (int i = 0; i < W; i++) begin
                if (iqtl_agree(q, i, ~q.lvl[i])) begin
                    d.lvl[i] = ~q.lvl[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q.cnt  <= '0;
            q.hist <= {(IQTL_HIST_LEN * W){IQTL_IDLE_LVL}};
            q.lvl  <= {W{IQTL_IDLE_LVL}};
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign qual_o = q.lvl;

    a_qual_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && period_i == '0) |=> qual_o == $past(pin_i))
        else $error("bypass does not pass input");

    a_qual_window: assert property (@(posedge clk_i) disable iff (rst_i)
        (period_i != '0 && $stable(period_i)) |-> q.cnt < iqtl_window(period_i))
        else $error("sample counter past its window");

    a_qual_agree: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(period_i) != '0 && qual_o != $past(qual_o))
        |-> ((($past(q.hist[0]) ^ qual_o) | ($past(q.hist[IQTL_HIST_LEN-1]) ^ qual_o))
             & (qual_o ^ $past(qual_o))) == '0)
        else $error("level accepted without six agreeing samples");

endmodule : iqtl_qual

// ### design/iqtl_soc.sv
`timescale 1ns/1ns
module iqtl_soc #(
    parameter int LOW_CYC = iqtl_pkg::IQTL_SOC_LOW_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic req_i,
    output logic      strobe_n_o
);
    import iqtl_pkg::*;

    typedef struct packed {
        logic                      low;
        logic [IQTL_SOC_CNT_W-1:0] cnt;
    } iqtl_sst_type;

    localparam logic [IQTL_SOC_CNT_W-1:0] LOAD = IQTL_SOC_CNT_W'(LOW_CYC - 1);

    iqtl_sst_type q;
    iqtl_sst_type d;

    // A request while the strobe is low is dropped: stretching would skew the conversion
    always_comb begin
        d = q;
        if (q.low) begin
            if (q.cnt == '0) begin
                d.low = 1'b0;
            end else begin
                d.cnt = q.cnt - IQTL_SOC_CNT_W'(1);
            end
        end else if (req_i) begin
            d.low = 1'b1;
            d.cnt = LOAD;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q.low <= 1'b0;
            q.cnt <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign strobe_n_o = ~q.low;

    a_soc_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req_i && strobe_n_o) |=> !strobe_n_o)
        else $error("strobe late to fall");

    a_soc_width: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(strobe_n_o) |-> $past(q.cnt) == '0)
        else $error("strobe released before its low time");

    c_soc_pulse: cover property (@(posedge clk_i) disable iff (rst_i) $rose(strobe_n_o));

endmodule : iqtl_soc

// ### design/iqtl_top.sv
`timescale 1ns/1ns
module iqtl_top #(
    parameter int SOC_LOW_CYC = iqtl_pkg::IQTL_SOC_LOW_CYC,
    parameter int INT_LAT_CYC = iqtl_pkg::IQTL_INT_LAT_CYC
) (
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    input  wire logic                               ce_i,
    input  wire logic [iqtl_pkg::IQTL_PRD_W-1:0]    qual_sample_period_field_i,
    input  iqtl_pkg::iqtl_pins_type                 pins_i,
    input  wire logic [iqtl_pkg::IQTL_NUM_INT-1:0]  int_rise_i,
    input  wire logic                               full_compare_output_enable_set_i,
    input  wire logic [iqtl_pkg::IQTL_NUM_PWM-1:0]  pwm_i,
    input  wire logic                               soc_req_i,
    input  wire logic [iqtl_pkg::IQTL_NUM_GPO-1:0]  gpo_i,
    output logic      [iqtl_pkg::IQTL_NUM_PWM-1:0]  pwm_o,
    output logic      [iqtl_pkg::IQTL_NUM_PWM-1:0]  pwm_oe_o,
    output logic                                    full_compare_output_enable_o,
    output iqtl_pkg::iqtl_fetch_type                fetch_o,
    output logic                                    adc_start_strobe_out_n_o,
    output logic      [iqtl_pkg::IQTL_NUM_GPO-1:0]  gpo_o
);
    import iqtl_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic                     out_en;
        logic [IQTL_NUM_PWM-1:0]  oe;
        logic [IQTL_NUM_PWM-1:0]  pwm;
        logic [IQTL_NUM_GPO-1:0]  gpo;
        logic [IQTL_NUM_INT-1:0]  int_lvl;
        logic [IQTL_NUM_INT-1:0]  pend;
        logic                     busy;
        logic [IQTL_LAT_W-1:0]    lat;
        logic [IQTL_IDX_W-1:0]    idx;
        iqtl_fetch_type           fetch;
    } iqtl_tst_type;

    localparam logic [IQTL_LAT_W-1:0] LAT_LOAD = IQTL_LAT_W'(INT_LAT_CYC - 1);
    localparam logic [IQTL_LAT_W-1:0] LAT_ONE  = 4'h1;

    iqtl_tst_type                q;
    iqtl_tst_type                d;
    iqtl_pins_type               qual;
    logic [IQTL_NUM_INT-1:0]     int_edge;
    logic [IQTL_NUM_INT-1:0]     pend_clr;

    // Lowest pending input wins; a fixed order keeps the fetch latency bounded
    function automatic logic [IQTL_IDX_W-1:0] iqtl_first(input logic [IQTL_NUM_INT-1:0] v);
        logic [IQTL_IDX_W-1:0] r;
        r = '0;
        for (int i = IQTL_NUM_INT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IQTL_IDX_W'(i);
            end
        end
        return r;
    endfunction : iqtl_first

    // ****************************************************************
    // Input qualification
    // ****************************************************************
    // All pins share one sampling counter; per-pin counters would cost
    // area and buy nothing since the period is common.
    iqtl_qual #(
        .W (IQTL_PIN_W)
    ) u_qual (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .period_i (qual_sample_period_field_i),
        .pin_i    (pins_i),
        .qual_o   (qual)
    );

    // ****************************************************************
    // Conversion strobe
    // ****************************************************************
    iqtl_soc #(
        .LOW_CYC (SOC_LOW_CYC)
    ) u_soc (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .req_i      (soc_req_i),
        .strobe_n_o (adc_start_strobe_out_n_o)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d             = q;
        pend_clr      = '0;
        d.fetch.valid = 1'b0;

        // Output data passes one flop so pins switch right after the edge
        d.pwm = pwm_i;
        d.gpo = gpo_i;

        // Protect low keeps the enable clear; software must set it again
        if (!qual.pdp_n) begin
            d.out_en = 1'b0;
        end else if (full_compare_output_enable_set_i) begin
            d.out_en = 1'b1;
        end

        for (int g = 0; g < IQTL_NUM_TRIP; g++) begin
            d.oe[2*g +: 2] = {2{d.out_en & qual.trip_n[g]}};
        end

        // Edge against the last qualified level, polarity per input
        int_edge  = (qual.ext_int ^ q.int_lvl) & ~(qual.ext_int ^ int_rise_i);
        d.int_lvl = qual.ext_int;

        if (q.busy) begin
            if (q.lat == '0) begin
                d.busy        = 1'b0;
                d.fetch.valid = 1'b1;
                d.fetch.idx   = q.idx;
            end else begin
                d.lat = q.lat - LAT_ONE;
            end
        end else if (|q.pend) begin
            d.busy   = 1'b1;
            d.lat    = LAT_LOAD;
            d.idx    = iqtl_first(q.pend);
            pend_clr = IQTL_NUM_INT'(1) << iqtl_first(q.pend);
        end

        // A new edge in the cycle its bit is taken stays pending
        d.pend = (q.pend & ~pend_clr) | int_edge;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q.out_en      <= IQTL_OE_RST;
            q.oe          <= {IQTL_NUM_PWM{IQTL_OE_RST}};
            q.pwm         <= '0;
            q.gpo         <= '0;
            q.int_lvl     <= {IQTL_NUM_INT{IQTL_IDLE_LVL}};
            q.pend        <= '0;
            q.busy        <= 1'b0;
            q.lat         <= '0;
            q.idx         <= '0;
            q.fetch.valid <= 1'b0;
            q.fetch.idx   <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign pwm_o                        = q.pwm;
    assign pwm_oe_o                     = q.oe;
    assign full_compare_output_enable_o = q.out_en;
    assign fetch_o                      = q.fetch;
    assign gpo_o                        = q.gpo;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Source-side hold times are not checked here: inputs are assumed to
    // meet them, and a shorter pulse is still accepted if it spans six samples, or at once in bypass.
    generate
        for (genvar g = 0; g < IQTL_NUM_TRIP; g++) begin : g_trip_chk
            a_trip_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
                (qual_sample_period_field_i == '0 && ce_i && !pins_i.trip_n[g])
                ##1 ce_i |=> pwm_oe_o[2*g +: 2] == 2'h0)
                else $error("trip did not float its PWM pair in time");
        end
    endgenerate

    a_pdp_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
        (qual_sample_period_field_i == '0 && ce_i && !pins_i.pdp_n)
        ##1 ce_i |=> (pwm_oe_o == '0 && !full_compare_output_enable_o))
        else $error("protect did not float the PWM outputs");

    a_pdp_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (!full_compare_output_enable_o && !full_compare_output_enable_set_i)
        |=> !full_compare_output_enable_o)
        else $error("output enable released without software");

    a_oe_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        !full_compare_output_enable_o |-> pwm_oe_o == '0)
        else $error("PWM driven while enable bit is clear");

    a_fetch_lat: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !q.busy && |q.pend) ##1 ce_i [*4] |=> fetch_o.valid)
        else $error("vector fetch later than its latency");

    a_fetch_src: assert property (@(posedge clk_i) disable iff (rst_i)
        fetch_o.valid |-> $past(q.busy) && $past(q.lat) == '0)
        else $error("vector fetch without a pending edge");

    a_edge_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && |int_edge) |=> (q.pend & $past(int_edge)) == $past(int_edge))
        else $error("interrupt edge lost");

    a_gpo_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> gpo_o == $past(gpo_i))
        else $error("output did not follow within one clock");

    c_trip: cover property (@(posedge clk_i) disable iff (rst_i)
        $fell(pwm_oe_o[0]) && full_compare_output_enable_o);

    c_pdp: cover property (@(posedge clk_i) disable iff (rst_i)
        $fell(full_compare_output_enable_o));

    c_fetch: cover property (@(posedge clk_i) disable iff (rst_i)
        fetch_o.valid && qual_sample_period_field_i != '0);

    c_two_ints: cover property (@(posedge clk_i) disable iff (rst_i)
        &q.pend);

endmodule : iqtl_top

// ### testbench/input_qualifier_trip_logic_tb.sv
`timescale 1ns/1ns
module input_qualifier_trip_logic_tb;
    import iqtl_pkg::*;

    localparam int SOC_LOW = IQTL_SOC_LOW_CYC;

    logic                    clk_i     = 1'b0;
    logic                    rst_i     = 1'b1;
    logic                    ce        = 1'b1;
    logic [IQTL_PRD_W-1:0]   prd       = 8'h00;
    logic [IQTL_NUM_INT-1:0] int_rise  = 2'h0;
    logic                    fc_set    = 1'b0;
    logic                    soc_req   = 1'b0;
    logic [IQTL_NUM_PWM-1:0] pwm_i     = 4'h0;
    logic [IQTL_NUM_GPO-1:0] gpo_i     = 4'h0;
    logic [IQTL_NUM_PWM-1:0] pwm_o;
    logic [IQTL_NUM_PWM-1:0] pwm_oe;
    logic                    fc_en;
    logic                    soc_n;
    logic [IQTL_NUM_GPO-1:0] gpo_o;
    iqtl_pins_type           pins;
    iqtl_fetch_type          fetch;
    int                      err_count = 0;
    int                      n_checks  = 0;

    always #20 clk_i = ~clk_i;

    iqtl_pin_src src_u (.clk_i(clk_i), .pins_o(pins));

    iqtl_top #(.SOC_LOW_CYC(SOC_LOW), .INT_LAT_CYC(IQTL_INT_LAT_CYC)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .qual_sample_period_field_i(prd), .pins_i(pins), .int_rise_i(int_rise),
        .full_compare_output_enable_set_i(fc_set), .pwm_i(pwm_i), .soc_req_i(soc_req),
        .gpo_i(gpo_i),
        .pwm_o(pwm_o), .pwm_oe_o(pwm_oe), .full_compare_output_enable_o(fc_en),
        .fetch_o(fetch), .adc_start_strobe_out_n_o(soc_n), .gpo_o(gpo_o));

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic end_of_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    // Qualification time in clocks for period n
    function automatic int qual_time(input int n);
        return 12 * n;
    endfunction : qual_time

    // Drive enables left after trip group g goes low
    function automatic logic [3:0] oe_after_trip(input int g);
        return 4'hF & ~(4'h3 << (2 * g));
    endfunction : oe_after_trip

    function automatic logic hit(input int which, input logic [3:0] val);
        case (which)
            0: return pwm_oe === val;
            1: return fetch.valid === 1'b1;
            default: return fc_en === val[0];
        endcase
    endfunction : hit

    // Counts edges until the event shows; running out ends the run
    task automatic wait_ev(input int which, input logic [3:0] val, input int max,
                           output int cyc);
        cyc = 0;
        do begin
            @(posedge clk_i);
            #1;
            cyc++;
        end while (!hit(which, val) && cyc < max);
        chk("event in time", {31'h0, hit(which, val)}, 32'h1);
        if (!hit(which, val)) begin
            end_of_test();
        end
    endtask : wait_ev

    task automatic pulse_wait(input int pin, input logic lvl, input int hold, input int which,
                              input logic [3:0] val, input int max, output int cyc);
        fork
            src_u.drive(pin, lvl, hold);
            begin
                @(posedge clk_i);
                wait_ev(which, val, max, cyc);
            end
        join
    endtask : pulse_wait

    // Counts cycles in which drives drop or a fetch starts
    task automatic watch(input int len, output int bad);
        bad = 0;
        repeat (len) begin
            @(posedge clk_i);
            #1;
            if (pwm_oe !== 4'hF || fetch.valid !== 1'b0) bad++;
        end
    endtask : watch

    task automatic enable_outputs();
        int cyc;
        fc_set = 1'b1;
        wait_ev(2, 4'h1, 2, cyc);
        fc_set = 1'b0;
        wait_ev(0, 4'hF, 2, cyc);
    endtask : enable_outputs

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int cyc;
        int bad;
        int n;
        int q;
        logic [3:0] exp_gpo;
        logic [3:0] exp_pwm;
        void'($urandom(65358));
        exp_gpo = 4'h0;
        exp_pwm = 4'h0;
        repeat (4) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        chk("oe at reset", pwm_oe, 4'h0);
        chk("enable at reset", fc_en, 1'b0);
        chk("strobe at reset", soc_n, 1'b1);
        // Every fourth edge runs with the enable low, so outputs must hold
        for (int i = 0; i < 16; i++) begin
            ce    = (i % 4 != 3);
            gpo_i = 4'($urandom);
            pwm_i = 4'($urandom);
            @(posedge clk_i);
            #1;
            if (ce) begin
                exp_gpo = gpo_i;
                exp_pwm = pwm_i;
            end
            chk("gpo", gpo_o, exp_gpo);
            chk("pwm", pwm_o, exp_pwm);
        end
        ce = 1'b1;
        enable_outputs();
        // Unqualified trips, each group alone
        for (int g = 0; g < IQTL_NUM_TRIP; g++) begin
            pulse_wait(2 + g, 1'b0, 2, 0, oe_after_trip(g), 3, cyc);
            src_u.drive(2 + g, 1'b1, 0);
            wait_ev(0, 4'hF, 3, cyc);
        end
        // Protect wins over a set and keeps drives off after release
        pulse_wait(4, 1'b0, 2, 0, 4'h0, 3, cyc);
        chk("enable cleared", fc_en, 1'b0);
        fc_set = 1'b1;
        @(posedge clk_i);
        #1;
        fc_set = 1'b0;
        src_u.drive(4, 1'b1, 3);
        #1;
        chk("enable kept off", fc_en, 1'b0);
        chk("oe kept off", pwm_oe, 4'h0);
        enable_outputs();
        // Interrupt on a rising edge only
        int_rise = 2'h2;
        fork
            src_u.drive(1, 1'b0, 2);
            watch(8, bad);
        join
        chk("no fetch on fall", bad, 0);
        pulse_wait(1, 1'b1, 2, 1, 4'h0, 12, cyc);
        chk("fetch index", fetch.idx, 1'h1);
        // Qualified trips and interrupts, top period last
        int_rise = 2'h0;
        for (int k = 0; k < 4; k++) begin
            n = (k == 3) ? 255 : $urandom_range(1, 4);
            q = qual_time(n);
            prd = 8'(n);
            repeat (4) @(posedge clk_i);
            // Glitch of at most 10n clocks covers at most five samples
            fork
                begin
                    src_u.drive(2, 1'b0, $urandom_range(1, 10 * n - 1));
                    src_u.drive(2, 1'b1, 0);
                end
                watch(11 * n + q + 4, bad);
            join
            chk("glitch ignored", bad, 0);
            watch(q + 4, bad);
            chk("quiet after glitch", bad, 0);
            pulse_wait(2, 1'b0, src_u.min_hold(n), 0, 4'hC, q + 2, cyc);
            chk("not before six samples", {31'h0, cyc >= 10 * n}, 32'h1);
            src_u.drive(2, 1'b1, 0);
            wait_ev(0, 4'hF, q + 2, cyc);
            pulse_wait(0, 1'b0, src_u.min_hold(n), 1, 4'h0, q + 12, cyc);
            chk("fetch index", fetch.idx, 1'h0);
            fork
                src_u.drive(0, 1'b1, 1 + q);
                watch(q + 6, bad);
            join
            chk("no fetch on rise", bad, 0);
        end
        // Strobe length with a request dropped while low
        soc_req = 1'b1;
        @(posedge clk_i);
        #1;
        soc_req = 1'b0;
        chk("strobe fall", soc_n, 1'b0);
        cyc = 1;
        for (int i = 0; i < SOC_LOW + 8; i++) begin
            soc_req = (i == 10);
            @(posedge clk_i);
            #1;
            if (soc_n !== 1'b0) break;
            cyc++;
        end
        soc_req = 1'b0;
        chk("strobe low cycles", cyc, SOC_LOW);
        end_of_test();
    end
endmodule : input_qualifier_trip_logic_tb

// ### testbench/iqtl_pin_src.sv
`timescale 1ns/1ns
module iqtl_pin_src (
    input  wire logic               clk_i,
    output iqtl_pkg::iqtl_pins_type pins_o
);
    import iqtl_pkg::*;

    // ****************************************************************
    // Pin driver
    // ****************************************************************
    // Pins are pulled up, so idle is high
    initial begin
        pins_o = '1;
    end

    // Shortest hold of a new level for sampling period n
    function automatic int min_hold(input int n);
        return (n == 0) ? 2 : 1 + 12 * n;
    endfunction : min_hold

    // Moves one pin just after an edge and holds it len edges; a len
    // below min_hold is asked for to make a glitch on purpose, or as 0 to release a pin
    task automatic drive(input int pin, input logic lvl, input int len);
        @(posedge clk_i);
        #1;
        pins_o[pin] = lvl;
        repeat (len) @(posedge clk_i);
    endtask : drive
endmodule : iqtl_pin_src
